//--- logic/tslog_core.sv
// module: time-stamped event message log with markers, diagnosis and time forwarding
// Overview of operation
// RULE1 - markers are produced only while time stamping is enabled
// RULE2 - at most 15 records; when all occupied further messages are discarded
// RULE3 - last entry before discarding is buffer overflow incoming
// RULE4 - first entry after a record frees is buffer overflow outgoing
// RULE5 - on start-up re-raise interrupt for each occupied uncollected record
// RULE6 - start-up: begin marker, pre-stop changes, input states, end marker
// RULE7 - changeover suspends stamping, bracketed by changeover begin and end
// RULE8 - redundancy link loss gives loss marker incoming, restore gives outgoing
// RULE9 - reading diagnosis record 240 returns an 80-byte status block
// RULE10 - record read outcome uses acyclic-service return values
// RULE11 - with synchronization enabled, forward time of day onto backplane
// RULE12 - backplane sync repeats at the configured fieldbus interval
// RULE13 - forwarded time deviates from received time by at most 10 ms
// RULE14 - group synchronize/freeze stays off in redundant operation
// RULE15 - redundant use needs fail-safe master, else halt and flash fault
// RULE16 - master uses only basic cyclic exchange when redundancy set by file
// RULE17 - special codes 01h,02h,04h,05h,06h,07h,08h as defined
// RULE18 - property 01h begin or incoming, 00h end or outgoing
// RULE19 - stamp is 8 bytes: seconds bytes 0-3, 2^-32 s fraction 4-7
// RULE20 - records fill in order, released only after master collects them
// RULE21 - each special message carries the time of its detection
`timescale 1ns/1ps
module tslog_core
  import tslog_pkg::*;
#(
  parameter int N_IN = 16,
  parameter int EAW = 3,
  parameter int MS_CYC = tslog_pkg::CYC_PER_MS,
  parameter int BLINK_CYC = tslog_pkg::BLINK_HALF_CYC,
  parameter logic [7:0] IO_SLOT = 8'h04
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stamp_en,
  input wire logic sync_en,
  input wire logic [15:0] sync_interval_ms,
  input wire logic redundant,
  input wire logic failsafe_ok,
  input wire logic group_cmd_req,
  output logic sync_freeze_en,
  input wire logic [tslog_pkg::STAMP_W-1:0] time_now,
  input wire logic start_req,
  input wire logic link_ok_pin,
  input wire logic changeover_pin,
  input wire logic sig_valid,
  output logic sig_ready,
  input wire logic [7:0] sig_slot,
  input wire logic [7:0] sig_chan,
  input wire logic [7:0] sig_prop,
  input wire logic [N_IN-1:0] in_state,
  input wire logic [N_IN-1:0] in_edge_rise,
  output logic proc_irq,
  output logic [tslog_pkg::REC_AW-1:0] proc_irq_rec,
  input wire logic rd_req,
  input wire logic [tslog_pkg::REC_AW-1:0] rd_rec,
  input wire logic [EAW-1:0] rd_ent,
  output logic rd_valid,
  output logic [tslog_pkg::ENT_W-1:0] rd_data,
  input wire logic collect,
  input wire logic [tslog_pkg::REC_AW-1:0] collect_rec,
  input wire logic diag_read_req,
  input wire logic [7:0] diag_index,
  output logic diag_valid,
  output logic [7:0] diag_data,
  output logic diag_last,
  output logic diag_done,
  output logic [7:0] diag_status,
  output logic tsync_valid,
  output logic [tslog_pkg::STAMP_W-1:0] tsync_time,
  output logic run_enable,
  output logic bus_fault_indicator
);
  import tslog_pkg::*;

  localparam logic [EAW-1:0] ENT_MAX = '1;
  localparam int IAW = (N_IN > 1) ? $clog2(N_IN) : 1;
  localparam logic [IAW-1:0] IN_LAST = IAW'(N_IN - 1);
  localparam logic [REC_AW-1:0] REC_LAST = REC_AW'(NUM_REC - 1);
  localparam logic [1:0] SYNC_RST = 2'h2;

  function automatic logic [REC_AW-1:0] lowest_free(input logic [NUM_REC-1:0] v);
    logic [REC_AW-1:0] r;
    r = '0;
    for (int i = NUM_REC - 1; i >= 0; i--)
    begin
      if (v[i]) r = REC_AW'(i);
    end
    return r;
  endfunction : lowest_free

  // ==================================================================
  // pin synchronisers: bit1 link ok, bit0 changeover
  logic [1:0] sync1, sync2, sync_prev;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync_prev <= SYNC_RST;
    end
    else
    begin
      sync1 <= {link_ok_pin, changeover_pin};
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end
  wire link_ok = sync2[1];
  wire chg_act = sync2[0];
  wire chg_edge = sync2[0] ^ sync_prev[0];
  wire link_edge = (sync2[1] ^ sync_prev[1]) & redundant;

  // ==================================================================
  // pending markers, stamped when the condition is seen
  tslog_state_t state, next_state;
  logic pend_chg, pend_loss;
  logic [7:0] chg_prop, loss_prop;
  logic [STAMP_W-1:0] chg_stamp, loss_stamp;
  logic cand_take;
  wire in_run = (state == ST_RUN);
  wire sel_chg = in_run && pend_chg;
  wire sel_loss = in_run && !pend_chg && pend_loss;
  wire sel_sig_run = in_run && !pend_chg && !pend_loss && sig_valid && stamp_en && !chg_act;
  wire sel_sig = sel_sig_run || (state == ST_PRESTOP && sig_valid);
  wire drop_sig = in_run && sig_valid && (!stamp_en || chg_act); // [RULE7]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pend_chg <= 1'b0;
      pend_loss <= 1'b0;
      chg_prop <= PROP_END;
      loss_prop <= PROP_END;
      chg_stamp <= '0;
      loss_stamp <= '0;
    end
    else
    begin
      if (stamp_en && chg_edge) // [RULE1] [RULE7] [RULE21]
      begin
        pend_chg <= 1'b1;
        chg_prop <= chg_act ? PROP_BEGIN : PROP_END;
        chg_stamp <= time_now;
      end
      else if (sel_chg && cand_take)
        pend_chg <= 1'b0;
      if (stamp_en && link_edge) // [RULE1] [RULE8] [RULE21]
      begin
        pend_loss <= 1'b1;
        loss_prop <= link_ok ? PROP_END : PROP_BEGIN;
        loss_stamp <= time_now;
      end
      else if (sel_loss && cand_take)
        pend_loss <= 1'b0;
    end
  end

  // ==================================================================
  // candidate entry selection
  logic [IAW-1:0] in_idx;
  logic [REC_AW-1:0] scan;
  wire [7:0] in_prop = (in_state[in_idx] == in_edge_rise[in_idx]) ? PROP_BEGIN : PROP_END;
  wire st_mark = (state == ST_BEGIN) || (state == ST_END);
  wire cand_valid = st_mark || (state == ST_INPUTS) || sel_chg || sel_loss || sel_sig;
  wire [ENT_W-1:0] cand_data = // [RULE6] [RULE17] [RULE18] [RULE19]
    (state == ST_BEGIN) ? tslog_entry(SPECIAL_SLOT, CODE_STARTUP, PROP_BEGIN, time_now) :
    (state == ST_END) ? tslog_entry(SPECIAL_SLOT, CODE_STARTUP, PROP_END, time_now) :
    (state == ST_INPUTS) ? tslog_entry(IO_SLOT, 8'(in_idx), in_prop, time_now) :
    sel_chg ? tslog_entry(SPECIAL_SLOT, CODE_CHG, chg_prop, chg_stamp) :
    sel_loss ? tslog_entry(SPECIAL_SLOT, CODE_LOSS, loss_prop, loss_stamp) :
    tslog_entry(sig_slot, sig_chan, sig_prop, time_now);

  // ==================================================================
  // record allocation, overflow handling
  logic open, ovf;
  logic [REC_AW-1:0] cur_rec;
  logic [EAW-1:0] cur_ent;
  logic [NUM_REC-1:0] occ;
  wire [NUM_REC-1:0] open_vec = open ? (ONE_REC << cur_rec) : '0;
  wire [NUM_REC-1:0] free_vec = ~occ & ~open_vec;
  wire no_free = ~|free_vec; // [RULE2]
  // outgoing overflow is a marker too, so it waits while stamping is off
  wire need_ovf_out = ovf && !no_free && stamp_en && (state != ST_REPLAY); // [RULE1] [RULE4]
  assign cand_take = cand_valid && !need_ovf_out;
  wire last_slot = open && (cur_ent == ENT_MAX) && no_free;
  wire wr_store = cand_take && !ovf && (open || !no_free); // [RULE2]
  wire wr_ovf_in = wr_store && last_slot; // [RULE3]
  wire wr_en = need_ovf_out || wr_store;
  wire [REC_AW-1:0] wr_rec = open ? cur_rec : lowest_free(free_vec); // [RULE20]
  wire [EAW-1:0] wr_ent = open ? cur_ent : '0;
  wire [ENT_W-1:0] wr_data =
    need_ovf_out ? tslog_entry(SPECIAL_SLOT, CODE_OVF, PROP_END, time_now) :
    wr_ovf_in ? tslog_entry(SPECIAL_SLOT, CODE_OVF, PROP_BEGIN, time_now) : cand_data;
  wire close_now = wr_en && ((wr_ent == ENT_MAX) || (state == ST_END));
  wire [NUM_REC-1:0] close_vec = close_now ? (ONE_REC << wr_rec) : '0;
  // release only what the master really collected
  wire [NUM_REC-1:0] rel_vec = collect ? (occ & (ONE_REC << collect_rec)) : '0; // [RULE20]
  wire replay_hit = (state == ST_REPLAY) && occ[scan]; // [RULE5]
  assign sig_ready = (sel_sig && cand_take) || drop_sig;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      open <= 1'b0;
      ovf <= 1'b0;
      cur_rec <= '0;
      cur_ent <= '0;
      occ <= '0;
    end
    else
    begin
      open <= wr_en ? !close_now : open;
      cur_rec <= wr_en ? wr_rec : cur_rec;
      cur_ent <= wr_en ? wr_ent + 1'b1 : cur_ent;
      ovf <= wr_ovf_in || (ovf && !need_ovf_out); // [RULE3] [RULE4]
      occ <= (occ & ~rel_vec) | close_vec;
    end
  end

  // ==================================================================
  // start-up sequencer; occupied records survive a restart request
  always_comb
  begin
    next_state = state;
    case (state)
      ST_REPLAY: if (scan == REC_LAST) next_state = stamp_en ? ST_BEGIN : ST_RUN;
      ST_BEGIN: if (cand_take) next_state = ST_PRESTOP;
      ST_PRESTOP: if (!sig_valid) next_state = ST_INPUTS;
      ST_INPUTS: if (cand_take && in_idx == IN_LAST) next_state = ST_END;
      ST_END: if (cand_take) next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ST_REPLAY;
      scan <= '0;
      in_idx <= '0;
      proc_irq <= 1'b0;
      proc_irq_rec <= '0;
    end
    else
    begin
      state <= start_req ? ST_REPLAY : next_state; // [RULE6]
      scan <= (state == ST_REPLAY && !start_req) ? scan + 1'b1 : '0;
      in_idx <= (state != ST_INPUTS) ? '0 : in_idx + IAW'(cand_take);
      proc_irq <= close_now || replay_hit; // [RULE5]
      proc_irq_rec <= close_now ? wr_rec : scan;
    end
  end

  tslog_mem #(.AW(REC_AW + EAW), .DW(ENT_W)) u_mem (
    .clk(clk),
    .we(wr_en),
    .waddr({wr_rec, wr_ent}),
    .wdata(wr_data),
    .raddr({rd_rec, rd_ent}),
    .rdata(rd_data)
  );

  // ==================================================================
  // diagnosis record 240
  logic diag_busy;
  logic [6:0] diag_cnt;
  wire [7:0] diag_flags = {!run_enable, redundant, sync_en, stamp_en, link_ok, chg_act, open, ovf};
  wire [7:0] diag_byte = (diag_cnt == 7'h00) ? diag_flags :
    (diag_cnt == 7'h01) ? 8'($countones(occ)) :
    (diag_cnt == 7'h02) ? occ[7:0] :
    (diag_cnt == 7'h03) ? {1'b0, occ[NUM_REC-1:8]} : 8'h00;
  wire diag_start = diag_read_req && !diag_busy;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_valid <= 1'b0;
      diag_busy <= 1'b0;
      diag_cnt <= '0;
      diag_valid <= 1'b0;
      diag_data <= 8'h00;
      diag_last <= 1'b0;
      diag_done <= 1'b0;
      diag_status <= RET_OK;
    end
    else
    begin
      rd_valid <= rd_req;
      diag_busy <= (diag_start && diag_index == DIAG_INDEX) ||
        (diag_busy && diag_cnt != DIAG_LAST_BYTE); // [RULE9]
      diag_cnt <= diag_busy ? diag_cnt + 1'b1 : '0;
      diag_valid <= diag_busy;
      diag_data <= diag_busy ? diag_byte : 8'h00;
      diag_last <= diag_busy && diag_cnt == DIAG_LAST_BYTE;
      diag_done <= (diag_busy && diag_cnt == DIAG_LAST_BYTE) ||
        (diag_start && diag_index != DIAG_INDEX);
      if (diag_start)
        diag_status <= (diag_index == DIAG_INDEX) ? RET_OK : RET_BAD_INDEX; // [RULE10]
    end
  end

  // ==================================================================
  // backplane time forwarding and redundancy guards
  logic [31:0] ms_cnt, blink_cnt;
  logic [15:0] int_cnt;
  logic blink;
  wire ms_tick = (ms_cnt == 32'(MS_CYC - 1));
  wire int_hit = ms_tick && (int_cnt + 16'h0001 >= sync_interval_ms);
  wire fault = redundant && !failsafe_ok;

  always_ff @(posedge clk)
  begin
    if (!reset_n || !sync_en)
    begin
      ms_cnt <= '0;
      int_cnt <= '0;
      tsync_valid <= 1'b0;
      tsync_time <= '0;
    end
    else
    begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
      int_cnt <= int_hit ? '0 : int_cnt + 16'(ms_tick); // [RULE12]
      tsync_valid <= int_hit; // [RULE11]
      // one-cycle copy keeps the deviation far inside the 10 ms bound
      tsync_time <= int_hit ? time_now : tsync_time; // [RULE13]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
      run_enable <= 1'b0;
      bus_fault_indicator <= 1'b0;
      sync_freeze_en <= 1'b0;
    end
    else
    begin
      blink_cnt <= (blink_cnt == 32'(BLINK_CYC - 1)) ? '0 : blink_cnt + 1'b1;
      blink <= blink ^ (blink_cnt == 32'(BLINK_CYC - 1));
      run_enable <= !fault; // [RULE15]
      bus_fault_indicator <= fault && blink; // [RULE15]
      sync_freeze_en <= group_cmd_req && !redundant; // [RULE14]
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire wr_special = wr_data[ENT_W-1:ENT_SLOT_LSB] == SPECIAL_SLOT;
  wire [7:0] wr_code = wr_data[ENT_SLOT_LSB-1:ENT_CODE_LSB];
  wire [7:0] wr_prop = wr_data[ENT_CODE_LSB-1:ENT_PROP_LSB];

  marker_gate_a: assert property (wr_en && wr_special |-> stamp_en) // [RULE1]
    else $error("marker written with stamping off");
  full_discard_a: assert property (ovf && no_free |-> !wr_en) // [RULE2]
    else $error("write while log full");
  ovf_in_a: assert property ($rose(ovf) |-> // [RULE3]
    $past(wr_en) && $past(wr_code) == CODE_OVF && $past(wr_prop) == PROP_BEGIN)
    else $error("overflow not marked incoming");
  ovf_out_a: assert property ($fell(ovf) |-> $past(wr_en) && $past(wr_ent) == '0 // [RULE4]
    && $past(wr_code) == CODE_OVF && $past(wr_prop) == PROP_END)
    else $error("overflow outgoing not first entry");
  replay_irq_a: assert property (replay_hit |=> proc_irq && proc_irq_rec == $past(scan)) // [RULE5]
    else $error("occupied record not replayed");
  startup_end_a: assert property (state == ST_END && wr_store |-> // [RULE6]
    wr_code == CODE_STARTUP && wr_prop == PROP_END ##1 state == ST_RUN)
    else $error("start-up end marker wrong");
  chg_quiet_a: assert property (chg_act && in_run && wr_en |-> wr_special) // [RULE7]
    else $error("stamping during changeover");
  tsync_time_a: assert property (tsync_valid |-> // [RULE11] [RULE13]
    tsync_time == $past(time_now) && $past(sync_en))
    else $error("forwarded time wrong");
  freeze_off_a: assert property (redundant [*2] |-> !sync_freeze_en) // [RULE14]
    else $error("freeze enabled in redundancy");
  diag_len_a: assert property (diag_last |-> // [RULE9]
    diag_valid && diag_done && diag_status == RET_OK)
    else $error("diagnosis block length wrong");

  ovf_cycle_c: cover property ($rose(ovf) ##[1:1000] $fell(ovf));
  startup_c: cover property (state == ST_BEGIN ##[1:100] state == ST_RUN);
  diag_c: cover property (diag_start ##[1:90] diag_last);
  tsync_c: cover property (tsync_valid);

endmodule : tslog_core

//--- logic/tslog_mem.sv
// module: entry store with registered read port
`timescale 1ns/1ps
module tslog_mem #(
  parameter int AW = 7,
  parameter int DW = 96
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : tslog_mem

//--- logic/tslog_pkg.sv
// package: constants and types for the time-stamped event message log
package tslog_pkg;

  // ==================================================================
  // record store geometry
  localparam int NUM_REC = 15;
  localparam int REC_AW = 4;
  localparam int ENT_W = 96;
  localparam int STAMP_W = 64;
  localparam logic [NUM_REC-1:0] ONE_REC = 15'h0001;

  // ==================================================================
  // entry layout: slot, code, property, reserved, stamp (seconds high)
  localparam int ENT_SLOT_LSB = 88;
  localparam int ENT_CODE_LSB = 80;
  localparam int ENT_PROP_LSB = 72;
  localparam logic [7:0] ENT_RSV = 8'h00;
  localparam logic [7:0] SPECIAL_SLOT = 8'h02;

  // ==================================================================
  // special message codes and properties
  localparam logic [7:0] CODE_STARTUP = 8'h01;
  localparam logic [7:0] CODE_TFAIL = 8'h02;
  localparam logic [7:0] CODE_TDIFF = 8'h04;
  localparam logic [7:0] CODE_STOP = 8'h05;
  localparam logic [7:0] CODE_OVF = 8'h06;
  localparam logic [7:0] CODE_CHG = 8'h07;
  localparam logic [7:0] CODE_LOSS = 8'h08;
  localparam logic [7:0] PROP_BEGIN = 8'h01;
  localparam logic [7:0] PROP_END = 8'h00;

  // ==================================================================
  // diagnosis record and acyclic return values
  localparam logic [7:0] DIAG_INDEX = 8'hf0;
  localparam logic [6:0] DIAG_LAST_BYTE = 7'h4f;
  localparam logic [7:0] RET_OK = 8'h00;
  localparam logic [7:0] RET_BAD_INDEX = 8'hb0;

  // ==================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;

  // ==================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_REPLAY, ST_BEGIN, ST_PRESTOP, ST_INPUTS, ST_END, ST_RUN
  } tslog_state_t;

  function automatic logic [ENT_W-1:0] tslog_entry(input logic [7:0] slot,
    input logic [7:0] code, input logic [7:0] prop, input logic [STAMP_W-1:0] stamp);
    return {slot, code, prop, ENT_RSV, stamp};
  endfunction : tslog_entry

endpackage : tslog_pkg

//--- testbench/timestamp_message_log_tb.sv
// testbench: start-up, overflow, markers, diagnosis, time forwarding, fault
`timescale 1ns/1ps
module timestamp_message_log_tb;
  import tslog_pkg::*;
  logic clk = 1'b0;
  logic reset_n, stamp_en, sync_en, redundant, failsafe_ok, group_cmd_req, start_req;
  logic link_ok_pin, changeover_pin, sig_valid, diag_read_req, sig_ready, sync_freeze_en;
  logic proc_irq, rd_req, rd_valid, collect, diag_valid, diag_last, diag_done;
  logic tsync_valid, run_enable, bus_fault_indicator;
  logic [15:0] sync_interval_ms;
  logic [63:0] tsync_time;
  logic [63:0] time_now = 64'h0000_0001_0000_0000;
  logic [7:0] sig_slot, sig_chan, sig_prop, diag_index, diag_data, diag_status;
  logic [3:0] in_state, in_edge_rise, proc_irq_rec, rd_rec, collect_rec;
  logic [2:0] rd_ent;
  logic [95:0] rd_data, d;
  int miscompares = 0;
  int n_compared = 0;

  always #5 clk = ~clk;
  always @(negedge clk) time_now <= time_now + 64'h1;

  tslog_core #(.N_IN(4), .EAW(3), .MS_CYC(10), .BLINK_CYC(8)) DUT (
    .clk, .reset_n, .stamp_en, .sync_en, .sync_interval_ms, .redundant, .failsafe_ok,
    .group_cmd_req, .sync_freeze_en, .time_now, .start_req, .link_ok_pin, .changeover_pin,
    .sig_valid, .sig_ready, .sig_slot, .sig_chan, .sig_prop, .in_state, .in_edge_rise,
    .proc_irq, .proc_irq_rec, .rd_req, .rd_rec, .rd_ent, .rd_valid, .rd_data, .collect,
    .collect_rec, .diag_read_req, .diag_index, .diag_valid, .diag_data, .diag_last,
    .diag_done, .diag_status, .tsync_valid, .tsync_time, .run_enable, .bus_fault_indicator);

  tslog_master m (.clk, .proc_irq, .proc_irq_rec, .rd_valid, .rd_data, .rd_req, .rd_rec,
    .rd_ent, .collect, .collect_rec);

  // ==================================================================
  // shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic entry(input logic [3:0] rec, input logic [2:0] ent, input logic [23:0] exp);
    m.read_ent(rec, ent, d);
    check(64'(d[95:72]), 64'(exp));
  endtask : entry

  task automatic send_msgs(input int n, input logic [7:0] first);
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk);
      sig_valid = 1'b1;
      sig_chan = first + 8'(k);
      for (int w = 0; w < 50; w++)
      begin
        @(posedge clk);
        if (sig_ready === 1'b1)
          break;
      end
    end
    @(negedge clk);
    sig_valid = 1'b0;
  endtask : send_msgs

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // ==================================================================
  // scenarios
  task automatic t_startup;
    for (int w = 0; w < 100 && m.irq_q.size() < 1; w++)
      @(negedge clk);
    check(64'(m.irq_q.size()), 64'h1);
    check(64'(run_enable), 64'h1);
    entry(4'h0, 3'h0, 24'h020101);
    for (int i = 0; i < 4; i++)
      entry(4'h0, 3'(i + 1), {8'h04, 8'(i), 7'h0, in_state[i] == in_edge_rise[i]});
    entry(4'h0, 3'h5, 24'h020100);
    check(64'(d[63:32]), 64'h1);
    check(64'(d[31:0] < time_now[31:0]), 64'h1);
    $display("test startup done");
  endtask : t_startup

  task automatic t_restart;
    @(negedge clk);
    start_req = 1'b1;
    @(negedge clk);
    start_req = 1'b0;
    for (int w = 0; w < 200 && m.irq_q.size() < 3; w++)
      @(negedge clk);
    check(64'(m.irq_q.size()), 64'h3);
    check(64'(m.irq_q[1]), 64'h0);
    entry(4'h1, 3'h0, 24'h020101);
    $display("test restart done");
  endtask : t_restart

  task automatic t_overflow;
    send_msgs(104, 8'h00);
    send_msgs(3, 8'hc0);
    check(64'(m.irq_q.size()), 64'h10);
    check(64'(m.irq_q[15]), 64'he);
    entry(4'h2, 3'h0, 24'h100001);
    entry(4'he, 3'h6, 24'h106601);
    entry(4'he, 3'h7, 24'h020601);
    m.release_rec(4'h5);
    repeat (4) @(negedge clk);
    entry(4'h5, 3'h0, 24'h020600);
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_markers;
    group_cmd_req = 1'b1;
    changeover_pin = 1'b1;
    repeat (6) @(negedge clk);
    send_msgs(1, 8'hbb);
    changeover_pin = 1'b0;
    repeat (6) @(negedge clk);
    check(64'(sync_freeze_en), 64'h1);
    redundant = 1'b1;
    link_ok_pin = 1'b0;
    repeat (6) @(negedge clk);
    check(64'(sync_freeze_en), 64'h0);
    link_ok_pin = 1'b1;
    repeat (6) @(negedge clk);
    stamp_en = 1'b0;
    changeover_pin = 1'b1;
    repeat (6) @(negedge clk);
    changeover_pin = 1'b0;
    repeat (6) @(negedge clk);
    stamp_en = 1'b1;
    send_msgs(1, 8'haa);
    entry(4'h5, 3'h1, 24'h020701);
    entry(4'h5, 3'h2, 24'h020700);
    entry(4'h5, 3'h3, 24'h020801);
    entry(4'h5, 3'h4, 24'h020800);
    entry(4'h5, 3'h5, 24'h10aa01);
    $display("test markers done");
  endtask : t_markers

  task automatic t_diag(input logic [7:0] idx, input int exp_n, input logic [7:0] exp_st);
    int n;
    int nl;
    logic [7:0] st, b1;
    n = 0;
    nl = 0;
    st = 'x;
    b1 = 'x;
    @(negedge clk);
    diag_read_req = 1'b1;
    diag_index = idx;
    @(negedge clk);
    diag_read_req = 1'b0;
    repeat (100)
    begin
      if (diag_valid === 1'b1)
      begin
        if (n == 1)
          b1 = diag_data;
        n++;
      end
      if (diag_last === 1'b1)
        nl++;
      if (diag_done === 1'b1)
        st = diag_status;
      @(negedge clk);
    end
    check(64'(n), 64'(exp_n));
    check(64'(nl), 64'(exp_n > 0));
    // records 0 to 14 closed except 5, which is reopened but not closed
    if (exp_n > 0)
      check(64'(b1), 64'h0e);
    check(64'(st), 64'(exp_st));
    $display("test diagnosis %h done", idx);
  endtask : t_diag

  task automatic t_tsync;
    int gap;
    gap = 0;
    repeat (60)
    begin
      if (tsync_valid === 1'b1)
        gap++;
      @(negedge clk);
    end
    check(64'(gap), 64'h0);
    sync_interval_ms = 16'h0002;
    sync_en = 1'b1;
    for (int w = 0; w < 100 && tsync_valid !== 1'b1; w++)
      @(negedge clk);
    check(64'(time_now - tsync_time <= 64'h2), 64'h1);
    gap = 0;
    do
    begin
      @(negedge clk);
      gap++;
    end
    while (tsync_valid !== 1'b1 && gap < 100);
    check(64'(gap), 64'h14);
    sync_en = 1'b0;
    $display("test time sync done");
  endtask : t_tsync

  task automatic t_fault;
    int tg;
    logic prev;
    tg = 0;
    failsafe_ok = 1'b0;
    repeat (4) @(negedge clk);
    check(64'(run_enable), 64'h0);
    prev = bus_fault_indicator;
    repeat (40)
    begin
      @(negedge clk);
      if (bus_fault_indicator !== prev)
        tg++;
      prev = bus_fault_indicator;
    end
    check(64'(tg >= 4), 64'h1);
    $display("test fault done");
  endtask : t_fault

  // ==================================================================
  // main sequence and watchdog
  initial
  begin
    {reset_n, sync_en, redundant, group_cmd_req, start_req, sig_valid, diag_read_req} = '0;
    {stamp_en, failsafe_ok, link_ok_pin} = 3'h7;
    changeover_pin = 1'b0;
    sync_interval_ms = 16'h0001;
    {sig_slot, sig_chan, sig_prop, diag_index} = {8'h10, 8'h00, 8'h01, 8'h00};
    in_state = 4'h5;
    in_edge_rise = 4'h3;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    t_startup();
    t_restart();
    t_overflow();
    t_markers();
    t_diag(8'hf0, 80, 8'h00);
    t_diag(8'h3c, 0, 8'hb0);
    t_tsync();
    t_fault();
    report_and_stop();
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : timestamp_message_log_tb

//--- testbench/tslog_master.sv
// fieldbus master model: reads log entries, releases records, logs interrupts
`timescale 1ns/1ps
module tslog_master
  import tslog_pkg::*;
(
  input wire logic clk,
  input wire logic proc_irq,
  input wire logic [tslog_pkg::REC_AW-1:0] proc_irq_rec,
  input wire logic rd_valid,
  input wire logic [tslog_pkg::ENT_W-1:0] rd_data,
  output logic rd_req,
  output logic [tslog_pkg::REC_AW-1:0] rd_rec,
  output logic [2:0] rd_ent,
  output logic collect,
  output logic [tslog_pkg::REC_AW-1:0] collect_rec
);
  logic [REC_AW-1:0] irq_q[$];

  initial
  begin
    rd_req = 1'b0;
    rd_rec = '0;
    rd_ent = '0;
    collect = 1'b0;
    collect_rec = '0;
  end

  always @(posedge clk)
  begin
    if (proc_irq === 1'b1)
      irq_q.push_back(proc_irq_rec);
  end

  // plain record reads only, no extended services
  task automatic read_ent(input logic [REC_AW-1:0] rec, input logic [2:0] ent,
    output logic [ENT_W-1:0] d);
    d = 'x;
    @(negedge clk);
    rd_req = 1'b1;
    rd_rec = rec;
    rd_ent = ent;
    @(negedge clk);
    rd_req = 1'b0;
    // released address must not keep looking valid
    rd_rec = ~rec;
    rd_ent = ~ent;
    for (int i = 0; i < 4; i++)
    begin
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        break;
      end
      @(negedge clk);
    end
  endtask : read_ent

  task automatic release_rec(input logic [REC_AW-1:0] rec);
    @(negedge clk);
    collect = 1'b1;
    collect_rec = rec;
    @(negedge clk);
    collect = 1'b0;
    collect_rec = ~rec;
  endtask : release_rec
endmodule : tslog_master
